// ==== core/ee_consts.svh ====
/*
 * Constants of the serial EEPROM write target: array shape, bit phases
 * and the self-timed write cycle.
 * Assumes a 100 ns system clock; included by bare name.
 */
`ifndef EE_CONSTS_SVH
`define EE_CONSTS_SVH

// ----------------------------------------------------------------
// Array shape
// ----------------------------------------------------------------
`define EE_ADDR_W     12
`define EE_PAGE_W     5
`define EE_PAGES      128
`define EE_PAGE_BYTES 32

// ----------------------------------------------------------------
// Bit phases within a nine-clock word
// ----------------------------------------------------------------
`define EE_ACK_BIT    4'h8
`define EE_LAST_BIT   4'h9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EE_CLK_NS     100
`define EE_TWC_NS     5000000
`define EE_TWC_CYC    (`EE_TWC_NS / `EE_CLK_NS)

`endif

// ==== core/ee_pkg.sv ====
/*
 * Types of the serial EEPROM write target.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ee_pkg;

   // ----------------------------------------------------------------
   // Protocol states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,    // Standby or unaddressed
      ST_DEV,     // Receiving device address
      ST_ADRH,    // Receiving upper word address
      ST_ADRL,    // Receiving lower word address
      ST_DATA,    // Receiving write data
      ST_READ     // Read mode, waits for STOP
   } ee_state_e;

   // Word address
   typedef logic [11:0] ee_addr_t;

endpackage : ee_pkg

// ==== core/ee_target.sv ====
/*
 * Two-wire serial EEPROM target, write path: START/STOP detection,
 * device address match, word address load, page buffer, self-timed
 * write cycle and acknowledge polling.
 * Assumes bus clock, data and pins arrive asynchronously and are
 * synchronised here; the data line is resolved outside from o_sda_oe.
 */
// Functional notes
// - Sample on clock rise, drive after fall
// - Data line only pulled low or released
// - Protect high blocks all programming
// - 128 pages of 32, 12-bit address
// - Falling data, clock high, is START
// - Rising data, clock high, is STOP
// - Standby after read STOP, or write done
// - Acknowledge low on ninth clock
// - Standby after power-up, read, programming
// - START, eighteen ones, START resets protocol
// - Device type nibble must match
// - Chip select bits match else standby
// - Eighth bit selects read or write
// - Two word-address bytes then data, acknowledged
// - STOP starts timed write, inputs ignored
// - Write cycle done within 5 ms
// - Up to 32 bytes per page
// - Only low five address bits increment
// - Overflow wraps and overwrites page bytes
// - No acknowledge while programming, polling
// - New START abandons pending write, keeps address
`include "ee_consts.svh"

module ee_target #(
   parameter logic [3:0] DEV_TYPE = 4'h5,         // Arbitrary value
   parameter int         TWC_CYC  = `EE_TWC_CYC   // Write cycle length
) (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic i_scl,
   input  wire logic i_sda,
   input  wire logic i_chip_select_pin_2,
   input  wire logic i_chip_select_pin_1,
   input  wire logic i_chip_select_pin_0,
   input  wire logic i_wp,
   output logic      o_sda_out,
   output logic      o_sda_oe,
   output logic      o_standby,
   output logic      o_busy
);

   localparam int TW = $clog2(TWC_CYC + 1);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1_q;    // First stage, read only by second
   logic [5:0] sync2_q;    // Second stage
   logic       scl_p_q;    // Previous synchronised clock
   logic       sda_p_q;    // Previous synchronised data

   // Two flops on every pin input
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sync1_q <= 6'h03;
         sync2_q <= 6'h03;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         sync1_q <= {i_wp, i_chip_select_pin_2, i_chip_select_pin_1,
                     i_chip_select_pin_0, i_sda, i_scl};
         sync2_q <= sync1_q;
         scl_p_q <= sync2_q[0];
         sda_p_q <= sync2_q[1];
      end
   end

   logic       scl_s;      // Synchronised bus clock
   logic       sda_s;      // Synchronised bus data
   logic [2:0] cs_s;       // Synchronised chip selects
   logic       wp_s;       // Synchronised protect
   logic       scl_rise;   // Bus clock rising
   logic       scl_fall;   // Bus clock falling
   logic       start_det;  // START seen
   logic       stop_det;   // STOP seen

   assign scl_s    = sync2_q[0];
   assign sda_s    = sync2_q[1];
   assign cs_s     = sync2_q[4:2];
   assign wp_s     = sync2_q[5];
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

   // ----------------------------------------------------------------
   // Device address decode
   // ----------------------------------------------------------------
   // Type nibble and chip selects match
   function automatic logic dev_match(input logic [7:0] w,
                                      input logic [2:0] cs);
      dev_match = (w[7:4] == DEV_TYPE) && (w[3:1] == cs);
   endfunction : dev_match

   // ----------------------------------------------------------------
   // Protocol state
   // ----------------------------------------------------------------
   ee_pkg::ee_state_e          state_q, state_d;   // Protocol state
   logic [3:0]                 bit_q, bit_d;       // Clocks in word
   logic [7:0]                 shr_q, shr_d;       // Shift register
   ee_pkg::ee_addr_t           addr_q, addr_d;     // Word address
   logic [`EE_PAGE_BYTES-1:0]  mask_q, mask_d;     // Bytes latched
   logic                       oe_q, oe_d;         // Pull line low
   logic [TW-1:0]              tmr_q, tmr_d;       // Write cycle timer
   logic                       stb_q, stb_d;       // Standby flag
   logic                       busy_q, busy_d;     // Registered busy output
   logic                       busy;               // Programming
   logic                       wr_byte;            // Data byte taken
   logic                       commit;             // Last timer cycle

   assign busy    = (tmr_q != '0);
   assign commit  = (tmr_q == TW'(1));
   assign wr_byte = scl_fall && (bit_q == `EE_ACK_BIT)
                    && (state_q == ee_pkg::ST_DATA);

   // Next-state logic of the protocol
   always_comb begin
      state_d = state_q;
      bit_d   = bit_q;
      shr_d   = shr_q;
      addr_d  = addr_q;
      mask_d  = mask_q;
      oe_d    = oe_q;
      tmr_d   = busy ? tmr_q - TW'(1) : tmr_q;
      if (start_det) begin
         state_d = ee_pkg::ST_DEV;
         bit_d   = 4'h0;
         oe_d    = 1'b0;
         if (!busy) begin
            mask_d = '0;
         end
      end else if (stop_det) begin
         if (state_q == ee_pkg::ST_DATA && mask_q != '0 && !wp_s && !busy) begin
            tmr_d = TW'(TWC_CYC);
         end
         state_d = ee_pkg::ST_IDLE;
         oe_d    = 1'b0;
      end else if (state_q != ee_pkg::ST_IDLE) begin
         if (scl_rise && bit_q < `EE_LAST_BIT) begin
            bit_d = bit_q + 4'h1;
            if (bit_q < `EE_ACK_BIT) begin
               shr_d = {shr_q[6:0], sda_s};
            end
         end else if (scl_fall && bit_q == `EE_LAST_BIT) begin
            // Ninth clock over, release
            bit_d = 4'h0;
            oe_d  = 1'b0;
         end else if (scl_fall && bit_q == `EE_ACK_BIT) begin
            unique case (state_q)
               ee_pkg::ST_DEV: begin
                  if (dev_match(shr_q, cs_s) && !busy) begin
                     oe_d = 1'b1;
                     state_d = shr_q[0] ? ee_pkg::ST_READ : ee_pkg::ST_ADRH;
                  end else begin
                     state_d = ee_pkg::ST_IDLE;
                  end
               end
               ee_pkg::ST_ADRH: begin
                  addr_d[11:8] = shr_q[3:0];
                  oe_d         = 1'b1;
                  state_d      = ee_pkg::ST_ADRL;
               end
               ee_pkg::ST_ADRL: begin
                  addr_d[7:0] = shr_q;
                  oe_d        = 1'b1;
                  state_d     = ee_pkg::ST_DATA;
               end
               ee_pkg::ST_DATA: begin
                  mask_d[addr_q[4:0]] = 1'b1;
                  addr_d[4:0]         = addr_q[4:0] + 5'h01;
                  oe_d                = 1'b1;
               end
               ee_pkg::ST_READ: begin
                  // Read data path lives elsewhere
                  oe_d = 1'b0;
               end
               ee_pkg::ST_IDLE: begin
                  oe_d = 1'b0;
               end
            endcase
         end
      end
      if (commit) begin
         mask_d = '0;
      end
      // standby when idle and not programming
      // after write, only once cycle ends
      stb_d = (state_d == ee_pkg::ST_IDLE) && (tmr_d == '0);
      // Busy output tracks the timer, from a flop
      busy_d = (tmr_d != '0);
   end

   // Protocol registers
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ee_pkg::ST_IDLE;
         bit_q   <= 4'h0;
         shr_q   <= 8'h00;
         addr_q  <= '0;
         mask_q  <= '0;
         oe_q    <= 1'b0;
         tmr_q   <= '0;
         stb_q   <= 1'b1;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_q   <= bit_d;
         shr_q   <= shr_d;
         addr_q  <= addr_d;
         mask_q  <= mask_d;
         oe_q    <= oe_d;
         tmr_q   <= tmr_d;
         stb_q   <= stb_d;
         busy_q  <= busy_d;
      end
   end

   // ----------------------------------------------------------------
   // Page buffer and array
   // ----------------------------------------------------------------
   logic [7:0] pbuf [`EE_PAGE_BYTES];                 // Page latches
   logic [7:0] mem  [`EE_PAGES * `EE_PAGE_BYTES];     // Array

   // Latch data bytes, program page at cycle end
   always_ff @(posedge i_clk) begin
      if (wr_byte) begin
         pbuf[addr_q[4:0]] <= shr_q;
      end
      if (commit) begin
         // program only the latched bytes, in one cycle
         for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
            if (mask_q[i]) begin
               mem[{addr_q[11:5], 5'(i)}] <= pbuf[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic sda_o_q;   // Output level, never high

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sda_o_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
      end
   end

   assign o_sda_out = sda_o_q;
   assign o_sda_oe  = oe_q;
   assign o_standby = stb_q;
   assign o_busy    = busy_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // output level stays low
   open_drain_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_sda_out == 1'b0)
      else $error("data line driven high");

   // drive begins only after falling clock
   drive_on_fall_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(o_sda_oe) |-> $past(scl_fall))
      else $error("acknowledge not after clock fall");

   start_restart_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      start_det |=> (state_q == ee_pkg::ST_DEV) && (bit_q == 4'h0) && !o_sda_oe)
      else $error("START did not restart");

   protect_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(busy) |-> !$past(wp_s) && $past(stop_det))
      else $error("write cycle under protect");

   cycle_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $rose(busy) |-> (tmr_q == TW'(TWC_CYC)) ##1 busy[*7])
      else $error("write cycle cut short");

   poll_nack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      busy && scl_fall && bit_q == `EE_ACK_BIT && state_q == ee_pkg::ST_DEV
      |=> !o_sda_oe)
      else $error("acknowledged while busy");

   page_row_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      wr_byte |=> addr_q[11:5] == $past(addr_q[11:5])
                  && addr_q[4:0] == $past(addr_q[4:0]) + 5'h01)
      else $error("page row or column wrong");

   ack_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      scl_fall && bit_q == `EE_LAST_BIT |=> !o_sda_oe && bit_q == 4'h0)
      else $error("acknowledge not released");

   standby_busy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      busy |-> !o_standby)
      else $error("standby during write cycle");

endmodule : ee_target

// ==== sim/ee_ctrl_model.sv ====
/* Two-wire bus controller model: drives clock, pulls data low.
   Assumes a pull-up resolves the data line outside. */
module ee_ctrl_model (
   input  wire logic i_clk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   int stretch = 0;  // Extra low clocks, slow controller

   // Idle bus, clock stands high
   initial begin
      o_scl    = 1'h1;
      o_sda_oe = 1'h0;
   end

   // Wait on falling system edges
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick

   task automatic send_bit(input logic b, output logic seen);
      o_scl = 1'h0;
      tick(2 + stretch);
      o_sda_oe = ~b;
      tick(2);
      o_scl = 1'h1;
      tick(2);
      seen = i_sda;
      tick(2);
   endtask : send_bit

   task automatic start();
      o_scl = 1'h0;
      tick(2);
      o_sda_oe = 1'h0;
      tick(2);
      o_scl = 1'h1;
      tick(4);
      o_sda_oe = 1'h1;
      tick(4);
   endtask : start

   task automatic stop();
      o_scl = 1'h0;
      tick(2);
      o_sda_oe = 1'h1;
      tick(2);
      o_scl = 1'h1;
      tick(4);
      o_sda_oe = 1'h0;
      tick(6);
   endtask : stop

   // byte msb first, ninth bit released
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         send_bit(d[i], seen);
      end
      send_bit(1'h1, seen);
      ack = ~seen;
   endtask : send_byte
endmodule : ee_ctrl_model

// ==== sim/ee_target_tb.sv ====
/* Self-checking bench for the EEPROM write target.
   Assumes design files and the controller model compile first. */
module ee_target_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         TWC   = 400;   // Short write cycle
   localparam logic [3:0] DTYPE = 4'h6;  // Arbitrary device type
   logic       clk, rst, wp, scl, ctrl_oe, sda_line;
   logic       sda_oe, sda_out, standby, busy, ack;
   logic [2:0] cs;
   int         fails, cmp_count;
   int         busy_cnt = 0;  // Falling edges seen busy

   // Open-drain line with pull-up
   assign sda_line = ~ctrl_oe & (sda_oe ? sda_out : 1'h1);

   ee_target #(.DEV_TYPE(DTYPE), .TWC_CYC(TWC)) u_dut (
      .i_clk(clk), .i_sys_rst(rst), .i_scl(scl), .i_sda(sda_line),
      .i_chip_select_pin_2(cs[2]), .i_chip_select_pin_1(cs[1]),
      .i_chip_select_pin_0(cs[0]), .i_wp(wp), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .o_standby(standby), .o_busy(busy));
   ee_ctrl_model u_ctrl (.i_clk(clk), .i_sda(sda_line), .o_scl(scl),
      .o_sda_oe(ctrl_oe));

   // 10 MHz clock
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Count cycles spent programming
   always @(negedge clk) begin
      if (busy === 1'h1) begin
         busy_cnt <= busy_cnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask : chk

   // One byte, acknowledge judged
   task automatic put(input logic [7:0] d, input logic exp_ack, input string what);
      u_ctrl.send_byte(d, ack);
      chk(ack, exp_ack, what);
      chk(sda_out, 1'h0, "line never driven high");
   endtask : put

   function automatic logic [7:0] dev(input logic rw);
      return {DTYPE, cs, rw};
   endfunction : dev

   task automatic head(input logic [7:0] hi, input logic [7:0] lo);
      u_ctrl.start();
      put(dev(1'h0), 1'h1, "write address");
      put(hi, 1'h1, "address high");
      put(lo, 1'h1, "address low");
   endtask : head

   // Close a write, poll while busy, time the cycle
   task automatic close_write();
      int busy_base;
      busy_base = busy_cnt;
      u_ctrl.stop();
      chk(busy, 1'h1, "cycle started");
      chk(standby, 1'h0, "standby during cycle");
      u_ctrl.start();
      put(dev(1'h0), 1'h0, "poll while busy");
      u_ctrl.stop();
      for (int k = 0; k < TWC + 100 && busy !== 1'h0; k++) begin
         @(negedge clk);
      end
      chk(busy_cnt - busy_base, TWC, "cycle length");
      chk(standby, 1'h1, "standby after cycle");
      u_ctrl.start();
      put(dev(1'h0), 1'h1, "poll when done");
      u_ctrl.stop();
      chk(busy, 1'h0, "no cycle without data");
   endtask : close_write

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(standby, 1'h1, "standby after reset");
      chk(busy, 1'h0, "busy after reset");
      chk(sda_oe, 1'h0, "line released");
   endtask : t_reset

   task automatic t_bad_addr();
      u_ctrl.start();
      put({DTYPE ^ 4'h1, cs, 1'h0}, 1'h0, "wrong type");
      u_ctrl.start();
      put({DTYPE, cs ^ 3'h1, 1'h0}, 1'h0, "wrong select");
      u_ctrl.stop();
      chk(standby, 1'h1, "standby on mismatch");
   endtask : t_bad_addr

   task automatic t_read();
      u_ctrl.start();
      put(dev(1'h1), 1'h1, "read address");
      u_ctrl.stop();
      chk(busy, 1'h0, "no cycle on read");
      chk(standby, 1'h1, "standby after read");
   endtask : t_read

   task automatic t_byte_write();
      head(8'h01, 8'h23);
      put(8'hA5, 1'h1, "data byte");
      close_write();
      chk(u_dut.mem[12'h123], 8'hA5, "byte programmed");
   endtask : t_byte_write

   task automatic t_protect();
      wp = 1'h1;
      head(8'h00, 8'h40);
      put(8'h3C, 1'h1, "protected data");
      u_ctrl.stop();
      repeat (20) @(negedge clk);
      chk(busy, 1'h0, "protected no cycle");
      wp = 1'h0;
   endtask : t_protect

   // Slow controller, one byte past the page
   task automatic t_page();
      u_ctrl.stretch = 6;
      head(8'hF0, 8'hE0);
      for (int i = 0; i < 33; i++) begin
         put(8'(i), 1'h1, "page data");
      end
      u_ctrl.stretch = 0;
      close_write();
      chk(u_dut.mem[12'h0E0], 8'h20, "wrapped byte");
      chk(u_dut.mem[12'h0E1], 8'h01, "second column");
      chk(u_dut.mem[12'h0FF], 8'h1F, "last column");
   endtask : t_page

   task automatic t_dummy();
      head(8'h00, 8'h10);
      u_ctrl.start();
      put(dev(1'h1), 1'h1, "read after dummy");
      u_ctrl.stop();
      chk(busy, 1'h0, "pending write dropped");
      chk(u_dut.addr_q, 12'h010, "address kept");
   endtask : t_dummy

   // Broken transfer, then recovery sequence
   task automatic t_soft_reset();
      u_ctrl.start();
      put(dev(1'h0), 1'h1, "before break");
      repeat (4) u_ctrl.send_bit(1'h1, ack);
      u_ctrl.start();
      repeat (18) u_ctrl.send_bit(1'h1, ack);
      u_ctrl.start();
      put(dev(1'h0), 1'h1, "after soft reset");
      u_ctrl.stop();
      chk(busy, 1'h0, "no cycle after recovery");
   endtask : t_soft_reset

   // Reset in mid write cycle drops the cycle
   task automatic t_mid_reset();
      head(8'h02, 8'h00);
      put(8'h5A, 1'h1, "data before reset");
      u_ctrl.stop();
      chk(busy, 1'h1, "cycle before reset");
      rst = 1'h1;
      repeat (2) @(negedge clk);
      chk(busy, 1'h0, "busy in reset");
      rst = 1'h0;
      repeat (3) @(negedge clk);
      chk(standby, 1'h1, "standby after mid reset");
      chk(sda_oe, 1'h0, "line released after reset");
      u_ctrl.start();
      put(dev(1'h0), 1'h1, "address after reset");
      u_ctrl.stop();
      chk(busy, 1'h0, "no cycle after reset");
   endtask : t_mid_reset

   task automatic results();
      if (fails == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   // Main sequence
   initial begin
      rst = 1'h1;
      wp = 1'h0;
      cs = 3'h5;
      fails = 0;
      cmp_count = 0;
      repeat (5) @(negedge clk);
      rst = 1'h0;
      repeat (4) @(negedge clk);
      t_reset();
      t_bad_addr();
      t_read();
      t_byte_write();
      t_protect();
      t_page();
      t_dummy();
      t_soft_reset();
      t_mid_reset();
      results();
   end

   // Watchdog, about four times the expected run
   initial begin
      #3000000;
      fails++;
      results();
   end
endmodule : ee_target_tb
